// [common/modbus_engine_defines.svh]
// Constants of the Modbus register access engine: codes, limits, offsets.
// Assumes frames arrive as whole Modbus application frames, one byte a beat.
`ifndef MODBUS_ENGINE_DEFINES_SVH
`define MODBUS_ENGINE_DEFINES_SVH
`define MB_FC_RD_HOLD 8'h03
`define MB_FC_RD_INPUT 8'h04
`define MB_FC_WR_SINGLE 8'h06
`define MB_FC_WR_MULTI 8'h10
`define MB_FC_RD_WR 8'h17
`define MB_EXC_FLAG 8'h80
`define MB_EXC_FUNC 8'h01
`define MB_EXC_ADDR 8'h02
`define MB_EXC_COUNT 8'h03
`define MB_READ_MAX 16'h007C
`define MB_WRITE_MAX 16'h0020
`define MB_MODULE_BASE 16'h8000
`define MB_MODULE_LAST 17'h0807F
`define MB_MOTOR_LAST 17'h003FF
`define MB_PORT 16'h01F6
`define MB_STATUS_REG 9'h023
`define MB_FRAME_MAX 81
`define MB_MIN_FRAME 7'h08
`define MB_HEAD_RD 4'h9
`define MB_HEAD_WR 4'hC
`define MB_LEN_WR 8'h06
`define MB_LEN_EXC 8'h03
`define MB_LEN_RD_BASE 8'h03
`define MB_DATA_W10 7'h0D
`define MB_DATA_W17 7'h11
`endif

// [common/modbus_engine_pkg.sv]
// Types shared by the Modbus register access engine and its bench.
// Assumes the constants header is on the include path.
package modbus_engine_pkg;
  typedef struct packed {
    logic valid;
    logic last;
    logic [7:0] data;
    logic [15:0] port;
  } rxByte_t;
  typedef struct packed {
    logic valid;
    logic last;
    logic [7:0] data;
  } txByte_t;
  typedef struct packed {
    logic valid;
    logic write;
    logic modSpace;
    logic [8:0] index;
    logic [31:0] data;
  } regReq_t;
  typedef enum logic [2:0] {
    S_IDLE, S_CHECK, S_WRITE, S_HEAD, S_READ, S_WORD, S_STATUS
  } state_t;
endpackage

// [core/modbus_register_access_engine.sv]
// Modbus application frame interpreter mapping 16-bit protocol registers
// onto 32-bit motor and module registers. Assumes a transport stack that
// delivers one frame per burst with its destination port, and a register
// store that answers each request with a one-cycle acknowledge.
`timescale 1ns/1ps
`include "modbus_engine_defines.svh"
module modbus_register_access_engine
  import modbus_engine_pkg::*;
#(
  parameter int FRAME_MAX = `MB_FRAME_MAX
) (
  input wire logic ref_clk,
  input wire logic resetn,
  input wire rxByte_t rx,
  output logic rxReady,
  output txByte_t tx,
  input wire logic txReady,
  output regReq_t regReq,
  input wire logic regAck,
  input wire logic [31:0] regRdata,
  input wire logic clientConnected,
  output logic runGreen,
  output logic runOrange,
  output logic [31:0] motorStatus
);

  function automatic logic [15:0] be16(input logic [7:0] hi, input logic [7:0] lo);
    return {hi, lo};
  endfunction

  // Range of protocol addresses a .. a+n-1 must fall in one register space
  function automatic logic addrOk(input logic [15:0] a, input logic [15:0] n);
    logic [16:0] lastA;
    lastA = {1'b0, a} + {1'b0, n} - 17'h00001;
    if (a[15])
      return (a >= `MB_MODULE_BASE) && (lastA <= `MB_MODULE_LAST);
    else
      return lastA <= `MB_MOTOR_LAST;
  endfunction

  function automatic logic readCountBad(input logic [15:0] n);
    return (n == 16'h0000) || (n > `MB_READ_MAX) || (n[0] && n != 16'h0001);
  endfunction

  function automatic logic writeCountBad(input logic [15:0] n, input logic [7:0] bc);
    return (n == 16'h0000) || (n > `MB_WRITE_MAX) || n[0] || ({8'h00, bc} != (n << 1));
  endfunction

  // Low 16 bits go first, each half big-endian
  function automatic logic [7:0] wordByte(input logic [31:0] w, input logic [1:0] k);
    case (k)
      2'h0: return w[15:8];
      2'h1: return w[7:0];
      2'h2: return w[31:24];
      default: return w[23:16];
    endcase
  endfunction

  state_t st_q, st_d;
  logic [7:0] buf_q [FRAME_MAX];
  logic [7:0] buf_d [FRAME_MAX];
  logic [6:0] idx_q, idx_d;
  logic [3:0] hb_q, hb_d;
  logic [4:0] cnt_q, cnt_d;
  logic [4:0] wrLeft_q, wrLeft_d;
  logic [7:0] exc_q, exc_d;
  logic [15:0] rdAddr_q, rdAddr_d;
  logic [15:0] wrAddr_q, wrAddr_d;
  logic [7:0] remain_q, remain_d;
  logic [31:0] word_q, word_d;
  logic [1:0] wb_q, wb_d;
  logic [1:0] wbEnd_q, wbEnd_d;
  logic saw35_q, saw35_d;
  logic [15:0] pendHigh_q, pendHigh_d;
  logic rxReady_q, rxReady_d;
  txByte_t tx_q, tx_d;
  regReq_t req_q, req_d;
  logic runGreen_q, runGreen_d;
  logic runOrange_q, runOrange_d;
  logic [31:0] status_q, status_d;

  logic [7:0] fc;
  logic [15:0] rA, rN, wA, wN;
  logic [7:0] wBc;
  logic [7:0] head [12];
  logic [3:0] headLen;
  logic [6:0] wBase;
  logic [6:0] wPos;
  logic canLoad;

  assign fc = buf_q[7];
  assign rA = be16(buf_q[8], buf_q[9]);
  assign rN = be16(buf_q[10], buf_q[11]);
  // Combined request: read addr, read count, write addr, write count, byte count
  assign wA = (fc == `MB_FC_RD_WR) ? be16(buf_q[12], buf_q[13]) : rA;
  assign wN = (fc == `MB_FC_RD_WR) ? be16(buf_q[14], buf_q[15]) : rN;
  assign wBc = (fc == `MB_FC_RD_WR) ? buf_q[16] : buf_q[12];
  assign wBase = (fc == `MB_FC_RD_WR) ? `MB_DATA_W17 : `MB_DATA_W10;
  assign wPos = wBase + {cnt_q, 2'b00};
  assign canLoad = !tx_q.valid || txReady;

  always_comb begin
    for (int i = 0; i < 12; i++) begin
      head[i] = 8'h00;
    end
    head[0] = buf_q[0];
    head[1] = buf_q[1];
    head[6] = buf_q[6];
    head[7] = fc;
    if (exc_q != 8'h00) begin
      head[5] = `MB_LEN_EXC;
      head[7] = fc | `MB_EXC_FLAG;
      head[8] = exc_q;
      headLen = `MB_HEAD_RD;
    end else if (fc == `MB_FC_WR_SINGLE || fc == `MB_FC_WR_MULTI) begin
      head[5] = `MB_LEN_WR;
      for (int i = 8; i < 12; i++) begin
        head[i] = buf_q[i];
      end
      headLen = `MB_HEAD_WR;
    end else begin
      head[8] = 8'(rN << 1);
      head[5] = `MB_LEN_RD_BASE + 8'(rN << 1);
      headLen = `MB_HEAD_RD;
    end
  end

  always_comb begin
    st_d = st_q;
    buf_d = buf_q;
    idx_d = idx_q;
    hb_d = hb_q;
    cnt_d = cnt_q;
    wrLeft_d = wrLeft_q;
    exc_d = exc_q;
    rdAddr_d = rdAddr_q;
    wrAddr_d = wrAddr_q;
    remain_d = remain_q;
    word_d = word_q;
    wb_d = wb_q;
    wbEnd_d = wbEnd_q;
    saw35_d = saw35_q;
    pendHigh_d = pendHigh_q;
    rxReady_d = rxReady_q;
    tx_d = tx_q;
    req_d = req_q;
    status_d = status_q;
    runGreen_d = clientConnected;
    runOrange_d = !clientConnected;
    if (canLoad) begin
      tx_d.valid = 1'b0;
      tx_d.last = 1'b0;
    end
    if (req_q.valid && regAck) begin
      req_d.valid = 1'b0;
    end
    case (st_q)
      S_IDLE: begin
        rxReady_d = 1'b1;
        if (rx.valid && rxReady_q) begin
          if (int'(idx_q) < FRAME_MAX) begin
            buf_d[idx_q] = rx.data;
            idx_d = idx_q + 7'h01;
          end
          if (rx.last) begin
            idx_d = 7'h00;
            // Other ports, short frames and foreign protocols vanish silently
            if (rx.port == `MB_PORT && idx_q + 7'h01 >= `MB_MIN_FRAME
                && buf_q[2] == 8'h00 && buf_q[3] == 8'h00) begin
              rxReady_d = 1'b0;
              st_d = S_CHECK;
            end
          end
        end
      end
      S_CHECK: begin
        exc_d = 8'h00;
        remain_d = 8'h00;
        wrLeft_d = 5'h00;
        cnt_d = 5'h00;
        hb_d = 4'h0;
        saw35_d = 1'b0;
        rdAddr_d = rA;
        wrAddr_d = wA;
        case (fc)
          `MB_FC_RD_HOLD, `MB_FC_RD_INPUT, `MB_FC_RD_WR: begin
            if (readCountBad(rN))
              exc_d = `MB_EXC_COUNT;
            else if ((rA[0] && rN != 16'h0001) || !addrOk(rA, rN))
              exc_d = `MB_EXC_ADDR;
            else if (fc == `MB_FC_RD_WR && writeCountBad(wN, wBc))
              exc_d = `MB_EXC_COUNT;
            else if (fc == `MB_FC_RD_WR && (wA[0] || !addrOk(wA, wN)))
              exc_d = `MB_EXC_ADDR;
            remain_d = rN[7:0];
            wrLeft_d = (fc == `MB_FC_RD_WR) ? wN[5:1] : 5'h00;
          end
          `MB_FC_WR_MULTI: begin
            if (writeCountBad(wN, wBc))
              exc_d = `MB_EXC_COUNT;
            else if (wA[0] || !addrOk(wA, wN))
              exc_d = `MB_EXC_ADDR;
            wrLeft_d = wN[5:1];
          end
          `MB_FC_WR_SINGLE: begin
            if (!addrOk(rA, 16'h0001))
              exc_d = `MB_EXC_ADDR;
            wrLeft_d = 5'h01;
          end
          default: exc_d = `MB_EXC_FUNC;
        endcase
        st_d = S_WRITE;
      end
      S_WRITE: begin
        if (exc_q != 8'h00 || wrLeft_q == 5'h00) begin
          st_d = S_HEAD;
        end else if (fc == `MB_FC_WR_SINGLE && rA[0]) begin
          // High word waits for its low partner
          pendHigh_d = be16(buf_q[10], buf_q[11]);
          wrLeft_d = 5'h00;
        end else if (!req_q.valid) begin
          req_d.valid = 1'b1;
          req_d.write = 1'b1;
          req_d.modSpace = wrAddr_q[15];
          req_d.index = wrAddr_q[9:1];
          if (fc == `MB_FC_WR_SINGLE)
            req_d.data = {pendHigh_q, be16(buf_q[10], buf_q[11])};
          else
            req_d.data = {buf_q[wPos + 7'h02], buf_q[wPos + 7'h03],
                          buf_q[wPos], buf_q[wPos + 7'h01]};
        end else if (regAck) begin
          cnt_d = cnt_q + 5'h01;
          wrLeft_d = wrLeft_q - 5'h01;
          wrAddr_d = wrAddr_q + 16'h0002;
        end
      end
      S_HEAD: begin
        if (canLoad) begin
          if (hb_q < headLen) begin
            tx_d.valid = 1'b1;
            tx_d.data = head[hb_q];
            tx_d.last = (hb_q == headLen - 4'h1) && (exc_q != 8'h00 || remain_q == 8'h00
                        || fc == `MB_FC_WR_SINGLE || fc == `MB_FC_WR_MULTI);
            hb_d = hb_q + 4'h1;
          end else if (exc_q == 8'h00 && remain_q != 8'h00
                       && fc != `MB_FC_WR_SINGLE && fc != `MB_FC_WR_MULTI) begin
            st_d = S_READ;
          end else begin
            st_d = S_STATUS;
          end
        end
      end
      S_READ: begin
        // One store access per register, so latency scales with the count
        if (!req_q.valid) begin
          req_d.valid = 1'b1;
          req_d.write = 1'b0;
          req_d.modSpace = rdAddr_q[15];
          req_d.index = rdAddr_q[9:1];
        end else if (regAck) begin
          word_d = regRdata;
          if (!rdAddr_q[15] && rdAddr_q[9:1] == `MB_STATUS_REG) begin
            saw35_d = 1'b1;
            status_d = regRdata;
          end
          if (remain_q == 8'h01) begin
            wb_d = rdAddr_q[0] ? 2'h2 : 2'h0;
            wbEnd_d = rdAddr_q[0] ? 2'h3 : 2'h1;
            remain_d = 8'h00;
          end else begin
            wb_d = 2'h0;
            wbEnd_d = 2'h3;
            remain_d = remain_q - 8'h02;
          end
          rdAddr_d = rdAddr_q + 16'h0002;
          st_d = S_WORD;
        end
      end
      S_WORD: begin
        if (canLoad) begin
          tx_d.valid = 1'b1;
          tx_d.data = wordByte(word_q, wb_q);
          tx_d.last = (wb_q == wbEnd_q) && (remain_q == 8'h00);
          wb_d = wb_q + 2'h1;
          if (wb_q == wbEnd_q)
            st_d = (remain_q == 8'h00) ? S_STATUS : S_READ;
        end
      end
      S_STATUS: begin
        // Module accesses never reach the motor, so only motor status is topped up
        // Input stays closed until the last reply byte has left
        if (saw35_q && canLoad) begin
          st_d = S_IDLE;
        end else if (!req_q.valid) begin
          req_d.valid = 1'b1;
          req_d.write = 1'b0;
          req_d.modSpace = 1'b0;
          req_d.index = `MB_STATUS_REG;
        end else if (regAck) begin
          status_d = regRdata;
          saw35_d = 1'b1;
        end
      end
      default: st_d = S_IDLE;
    endcase
  end

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      st_q <= S_IDLE;
      for (int i = 0; i < FRAME_MAX; i++) begin
        buf_q[i] <= 8'h00;
      end
      idx_q <= 7'h00;
      hb_q <= 4'h0;
      cnt_q <= 5'h00;
      wrLeft_q <= 5'h00;
      exc_q <= 8'h00;
      rdAddr_q <= 16'h0000;
      wrAddr_q <= 16'h0000;
      remain_q <= 8'h00;
      word_q <= 32'h00000000;
      wb_q <= 2'h0;
      wbEnd_q <= 2'h0;
      saw35_q <= 1'b0;
      pendHigh_q <= 16'h0000;
      rxReady_q <= 1'b0;
      tx_q <= '0;
      req_q <= '0;
      runGreen_q <= 1'b0;
      runOrange_q <= 1'b0;
      status_q <= 32'h00000000;
    end else begin
      st_q <= st_d;
      buf_q <= buf_d;
      idx_q <= idx_d;
      hb_q <= hb_d;
      cnt_q <= cnt_d;
      wrLeft_q <= wrLeft_d;
      exc_q <= exc_d;
      rdAddr_q <= rdAddr_d;
      wrAddr_q <= wrAddr_d;
      remain_q <= remain_d;
      word_q <= word_d;
      wb_q <= wb_d;
      wbEnd_q <= wbEnd_d;
      saw35_q <= saw35_d;
      pendHigh_q <= pendHigh_d;
      rxReady_q <= rxReady_d;
      tx_q <= tx_d;
      req_q <= req_d;
      runGreen_q <= runGreen_d;
      runOrange_q <= runOrange_d;
      status_q <= status_d;
    end
  end

  assign rxReady = rxReady_q;
  assign tx = tx_q;
  assign regReq = req_q;
  assign runGreen = runGreen_q;
  assign runOrange = runOrange_q;
  assign motorStatus = status_q;

endmodule // modbus_register_access_engine

// [dv/modbus_engine_monitor.sv]
// Port checker for the register access engine, bound to its top module.
// Assumes one clock and the register store acknowledging with a pulse.
`timescale 1ns/1ps
module modbus_engine_monitor
  import modbus_engine_pkg::*;
(
  input wire logic ref_clk,
  input wire logic resetn,
  input wire rxByte_t rx,
  input wire logic rxReady,
  input wire txByte_t tx,
  input wire logic txReady,
  input wire regReq_t regReq,
  input wire logic regAck,
  input wire logic [31:0] regRdata,
  input wire logic clientConnected,
  input wire logic runGreen,
  input wire logic runOrange,
  input wire logic [31:0] motorStatus
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!resetn);
  sequence txWait;
    tx.valid && !txReady;
  endsequence
  sequence txDone;
    tx.valid && txReady && tx.last;
  endsequence
  // Bit 41 down to 32 is the space flag and register number
  sequence statusAck;
    regReq.valid && !regReq.write && regReq[41:32] == 10'h023 && regAck;
  endsequence
  a_led_green: assert property (clientConnected |=> runGreen && !runOrange)
    else $error("run indicator not green while connected");
  a_led_orange: assert property (!clientConnected |=> runOrange && !runGreen)
    else $error("run indicator not orange while unconnected");
  a_tx_held: assert property (txWait |=> tx.valid && $stable(tx))
    else $error("reply byte changed before acceptance");
  a_req_held: assert property (regReq.valid && !regAck |=> regReq.valid && $stable(regReq))
    else $error("register request changed before acknowledge");
  a_req_clear: assert property (regAck |=> !regReq.valid)
    else $error("register request kept after acknowledge");
  a_status_capture: assert property (statusAck |=> motorStatus == $past(regRdata))
    else $error("status word not captured");
  a_write_first: assert property (regReq.valid && regReq.write |-> !tx.valid)
    else $error("write issued while reply under way");
  a_busy_rx: assert property (regReq.valid || tx.valid |-> !rxReady)
    else $error("frame input open while answering");
  a_answer_done: assert property (txDone |-> ##[1:60] rxReady)
    else $error("engine did not return to idle");
endmodule // modbus_engine_monitor

bind modbus_register_access_engine modbus_engine_monitor i_modbus_engine_monitor (
  .ref_clk(ref_clk), .resetn(resetn), .rx(rx), .rxReady(rxReady), .tx(tx),
  .txReady(txReady), .regReq(regReq), .regAck(regAck), .regRdata(regRdata),
  .clientConnected(clientConnected), .runGreen(runGreen), .runOrange(runOrange),
  .motorStatus(motorStatus)
);

// [dv/reg_store_model.sv]
// Behavioural motor and module register store behind the engine.
// Assumes requests hold until the one-cycle acknowledge.
`timescale 1ns/1ps
module reg_store_model
  import modbus_engine_pkg::*;
(
  input wire logic ref_clk,
  input wire logic resetn,
  input wire regReq_t regReq,
  input wire logic slow,
  output logic regAck,
  output logic [31:0] regRdata
);
  logic [31:0] mem [1024];
  int waitCnt;
  initial for (int k = 0; k < 1024; k++) mem[k] = 32'hC0A80000 | k;
  always @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      regAck <= 1'b0;
      waitCnt <= 0;
      regRdata <= 32'h0;
    end else if (regReq.valid && !regAck && waitCnt >= (slow ? 4 : 0)) begin
      regAck <= 1'b1;
      waitCnt <= 0;
      regRdata <= mem[regReq[41:32]];
      if (regReq.write) mem[regReq[41:32]] <= regReq.data;
    end else begin
      regAck <= 1'b0;
      waitCnt <= regReq.valid ? waitCnt + 1 : 0;
      // Data is only meaningful with the acknowledge
      regRdata <= ~regRdata;
    end
  end
endmodule // reg_store_model

// [dv/modbus_register_access_engine_tb.sv]
// Self-checking bench: acts as the network master, store model behind.
// Assumes the engine answers one whole frame before taking the next.
`timescale 1ns/1ps
module modbus_register_access_engine_tb
  import modbus_engine_pkg::*;
;
  typedef logic [7:0] bytes_t [$];
  logic ref_clk = 1'b0;
  logic resetn = 1'b0;
  logic txReady = 1'b0;
  logic clientConnected = 1'b0;
  logic slow = 1'b0;
  rxByte_t rx = '0;
  logic rxReady, regAck, runGreen, runOrange;
  txByte_t tx;
  regReq_t regReq;
  logic [31:0] regRdata, motorStatus;
  int mismatches = 0;
  int checked = 0;
  modbus_register_access_engine i_modbus_register_access_engine (.ref_clk(ref_clk),
    .resetn(resetn), .rx(rx), .rxReady(rxReady), .tx(tx), .txReady(txReady),
    .regReq(regReq), .regAck(regAck), .regRdata(regRdata),
    .clientConnected(clientConnected), .runGreen(runGreen), .runOrange(runOrange),
    .motorStatus(motorStatus));
  reg_store_model i_reg_store_model (.ref_clk(ref_clk), .resetn(resetn), .regReq(regReq),
    .slow(slow), .regAck(regAck), .regRdata(regRdata));
  initial forever #50 ref_clk = ~ref_clk;
  task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      mismatches++;
      $display("Error %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic final_report();
    $display("Checks %0d mismatches %0d", checked, mismatches);
    if (mismatches == 0 && checked > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  function automatic logic [31:0] val(input int k);
    return 32'hC0A80000 | k;
  endfunction
  function automatic bytes_t hdr(input logic [7:0] tid, input logic [7:0] len,
                                 input logic [7:0] fc);
    return {8'h00, tid, 8'h00, 8'h00, 8'h00, len, 8'h01, fc};
  endfunction
  function automatic bytes_t w(input logic [31:0] v);
    return {v[15:8], v[7:0], v[31:24], v[23:16]};
  endfunction
  task automatic send(input bytes_t f, input logic [15:0] port);
    int n;
    for (int i = 0; i < f.size(); i++) begin
      @(negedge ref_clk);
      rx <= '{1'b1, i == f.size() - 1, f[i], port};
      n = 0;
      while (rxReady !== 1'b1 && n++ < 200) @(negedge ref_clk);
      @(posedge ref_clk);
    end
    @(negedge ref_clk);
    rx <= '0;
  endtask
  // Sink stalls every third cycle so held reply bytes are exercised
  task automatic xfer(input bytes_t f, input bytes_t e);
    bytes_t got;
    logic done;
    int n;
    done = 1'b0;
    send(f, 16'h01F6);
    for (n = 0; n < 2000 && !(done && !txReady); n++) begin
      @(negedge ref_clk);
      txReady = !done && (n % 3 != 2);
      if (txReady && tx.valid === 1'b1) begin
        got.push_back(tx.data);
        done = tx.last;
      end
    end
    // Next poll only once the engine is idle again
    n = 0;
    while (rxReady !== 1'b1 && n++ < 200) @(negedge ref_clk);
    chk("idle", rxReady, 1'b1);
    chk("length", got.size(), e.size());
    foreach (e[i]) chk("byte", got[i], e[i]);
  endtask
  task automatic s_read();
    bytes_t e;
    xfer({hdr(8'h01, 8'h06, 8'h03), 8'h80, 8'h06, 8'h00, 8'h02},
         {hdr(8'h01, 8'h07, 8'h03), 8'h04, w(val(515))});
    chk("status", motorStatus, val(35));
    e = {hdr(8'h02, 8'hFB, 8'h04), 8'hF8};
    for (int k = 0; k < 62; k++) e = {e, w(val(k))};
    xfer({hdr(8'h02, 8'h06, 8'h04), 8'h00, 8'h00, 8'h00, 8'h7C}, e);
    xfer({hdr(8'h03, 8'h06, 8'h03), 8'h00, 8'h03, 8'h00, 8'h01},
         {hdr(8'h03, 8'h05, 8'h03), 8'h02, 8'hC0, 8'hA8});
  endtask
  task automatic s_exc();
    logic [47:0] tbl [8] = '{48'h03_0000_007E_03, 48'h03_0000_0003_03, 48'h04_0000_0000_03,
      48'h05_0000_0002_01, 48'h03_0800_0002_02, 48'h03_8080_0002_02, 48'h03_0001_0002_02,
      48'h10_0006_0022_03};
    foreach (tbl[i]) xfer({hdr(8'h04, 8'h06, tbl[i][47:40]), tbl[i][39:32], tbl[i][31:24],
      tbl[i][23:16], tbl[i][15:8]}, {hdr(8'h04, 8'h03, tbl[i][47:40] | 8'h80),
      tbl[i][7:0]});
  endtask
  task automatic s_write();
    bytes_t q;
    q = {8'h00, 8'h07, 8'h12, 8'h34};
    xfer({hdr(8'h05, 8'h06, 8'h06), q}, {hdr(8'h05, 8'h06, 8'h06), q});
    q = {8'h00, 8'h06, 8'h56, 8'h78};
    xfer({hdr(8'h05, 8'h06, 8'h06), q}, {hdr(8'h05, 8'h06, 8'h06), q});
    xfer({hdr(8'h06, 8'h0F, 8'h10), 8'h00, 8'h08, 8'h00, 8'h04, 8'h08, w(32'hA1B2C3D4),
      w(32'h0F1E2D3C)}, {hdr(8'h06, 8'h06, 8'h10), 8'h00, 8'h08, 8'h00, 8'h04});
    xfer({hdr(8'h07, 8'h06, 8'h03), 8'h00, 8'h06, 8'h00, 8'h06}, {hdr(8'h07, 8'h0F, 8'h03),
      8'h0C, w(32'h12345678), w(32'hA1B2C3D4), w(32'h0F1E2D3C)});
  endtask
  task automatic s_combined();
    xfer({hdr(8'h08, 8'h0F, 8'h17), 8'h80, 8'h06, 8'h00, 8'h02, 8'h00, 8'h0C, 8'h00, 8'h02,
      8'h04, w(32'hCAFEF00D)}, {hdr(8'h08, 8'h07, 8'h17), 8'h04, w(val(515))});
    xfer({hdr(8'h09, 8'h06, 8'h03), 8'h00, 8'h0C, 8'h00, 8'h02},
         {hdr(8'h09, 8'h07, 8'h03), 8'h04, w(32'hCAFEF00D)});
    // Low half alone is a negative 16-bit quantity for the master
    xfer({hdr(8'h0B, 8'h06, 8'h03), 8'h00, 8'h0C, 8'h00, 8'h01},
         {hdr(8'h0B, 8'h05, 8'h03), 8'h02, 8'hF0, 8'h0D});
  endtask
  task automatic s_drop_leds();
    logic seen;
    seen = 1'b0;
    send({hdr(8'h0A, 8'h06, 8'h03), 8'h00, 8'h00, 8'h00, 8'h02}, 16'h01F7);
    repeat (30) begin
      @(negedge ref_clk);
      seen = seen | (tx.valid !== 1'b0) | (rxReady !== 1'b1);
    end
    chk("dropped", seen, 1'b0);
    chk("orange", {runOrange, runGreen}, 2'b10);
    clientConnected = 1'b1;
    repeat (2) @(negedge ref_clk);
    chk("green", {runOrange, runGreen}, 2'b01);
  endtask
  initial begin
    #(20000 * 100);
    mismatches++;
    final_report();
  end
  initial begin
    repeat (2) @(negedge ref_clk);
    resetn = 1'b1;
    repeat (2) @(negedge ref_clk);
    s_drop_leds();
    s_read();
    slow = 1'b1;
    s_exc();
    s_write();
    slow = 1'b0;
    s_combined();
    final_report();
  end
endmodule // modbus_register_access_engine_tb
